// ===== logic/pci_pkg.sv
// Types shared by the pin change interrupt block.
// Assumes pci_regs.svh is on the include path.
`include "pci_regs.svh"

package pci_pkg;

  typedef logic [7:0] pci_byte_t;
  typedef logic [`PCI_NUM_PORTS-1:0][7:0] pci_pins_t;

  // Software-visible state of one port
  typedef struct packed {
    pci_byte_t rise;
    pci_byte_t fall;
    pci_byte_t flags;
  } pci_port_regs_t;

endpackage

// ===== logic/pci_port.sv
// One 8-pin port: edge enables, sticky flags, edge detection.
// Assumes pins are synchronous to pclk; writes come from pci_top.
`timescale 1ns/10ps
`include "pci_regs.svh"

module pci_port #(
  parameter pci_pkg::pci_byte_t AVAIL = `PCI_AVAIL_A
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire pci_pkg::pci_byte_t  pins,
  input  wire pci_pkg::pci_byte_t  det_mask,
  input  wire logic                wr_rise,
  input  wire logic                wr_fall,
  input  wire logic                wr_flag,
  input  wire pci_pkg::pci_byte_t  wdata,
  output pci_pkg::pci_port_regs_t  regs,
  output pci_pkg::pci_byte_t       hits
);
  import pci_pkg::*;

  pci_byte_t rise_reg, fall_reg, flag_reg, prev_reg;
  pci_byte_t flag_next, rose, fell;

  // ****************************************
  // Edge detection
  // ****************************************
  // Current sample against last registered sample
  assign rose = pins & ~prev_reg;
  assign fell = ~pins & prev_reg;
  // Per-pin enables, either or both directions
  assign hits = ((rose & rise_reg) | (fell & fall_reg))
              & AVAIL & det_mask;

  // Write stores, a fresh edge still sets
  assign flag_next = ((wr_flag ? wdata : flag_reg) | hits)
                   & AVAIL;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_reg <= `PCI_RST_BYTE;
      fall_reg <= `PCI_RST_BYTE;
      flag_reg <= `PCI_RST_BYTE;
      prev_reg <= `PCI_RST_BYTE;
    end else begin
      if (wr_rise) rise_reg <= wdata & AVAIL;
      if (wr_fall) fall_reg <= wdata & AVAIL;
      flag_reg <= flag_next;
      prev_reg <= pins;
    end
  end

  assign regs = '{rise: rise_reg, fall: fall_reg, flags: flag_reg};

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_rise_sets_flag: assert property (
    ##1 ((flag_reg & $past(pins & ~prev_reg & rise_reg & AVAIL
      & det_mask)) == $past(pins & ~prev_reg & rise_reg & AVAIL
      & det_mask)))
    else $error("enabled rising edge did not set flag");
  chk_fall_sets_flag: assert property (
    ##1 ((flag_reg & $past(~pins & prev_reg & fall_reg & AVAIL
      & det_mask)) == $past(~pins & prev_reg & fall_reg & AVAIL
      & det_mask)))
    else $error("enabled falling edge did not set flag");
  chk_only_enabled: assert property (
    !wr_flag |=> ((flag_reg & ~$past(flag_reg) & ~$past(hits)) == 0))
    else $error("flag set without enabled edge");
  chk_flag_sticky: assert property (
    !wr_flag |=> (($past(flag_reg) & ~flag_reg) == 0))
    else $error("flag cleared without a write");
  chk_set_wins: assert property (
    wr_flag |=> ((flag_reg & $past(hits)) == $past(hits)))
    else $error("edge lost during flag write");
  cov_set_wins: cover property (wr_flag && hits != 0 && wdata == 0);
endmodule

// ===== logic/pci_regs.svh
// Register indices, field positions and reset values of the
// pin change interrupt block.
// Assumes byte address = 4 * index on a 32-bit APB.
`ifndef PCI_REGS_SVH
`define PCI_REGS_SVH

// ****************************************
// Geometry
// ****************************************
`define PCI_NUM_PORTS   5
`define PCI_IDX_W       11
`define PCI_ADDR_W      13

// ****************************************
// Port base indices (rise, fall, flag follow)
// ****************************************
`define PCI_BASE_A      11'h405
`define PCI_BASE_B      11'h40D
`define PCI_BASE_C      11'h415
`define PCI_BASE_E      11'h425
`define PCI_BASE_W      11'h43D
`define PCI_OFS_RISE    11'h000
`define PCI_OFS_FALL    11'h001
`define PCI_OFS_FLAG    11'h002

// ****************************************
// Block control and status
// ****************************************
`define PCI_IDX_CTRL    11'h440
`define PCI_IDX_STAT    11'h441
`define PCI_CTRL_IE     0
`define PCI_CTRL_EXTRST 1
`define PCI_CTRL_LVP    2
`define PCI_CTRL_MASK   8'h07
`define PCI_STAT_SUM    0

// ****************************************
// Pin availability and reset values
// ****************************************
`define PCI_AVAIL_A     8'hFF
`define PCI_AVAIL_B     8'hFF
`define PCI_AVAIL_C     8'h7F
`define PCI_AVAIL_E     8'h08
`define PCI_AVAIL_W     8'hFF
`define PCI_RSTPIN_PORT 3
`define PCI_RSTPIN_BIT  3
`define PCI_RST_BYTE    8'h00

`endif

// ===== logic/pci_top.sv
// Pin change interrupt block: APB slave, five ports of edge detect.
// Assumes APB master in pclk domain and pins synchronous to pclk.
`timescale 1ns/10ps
`include "pci_regs.svh"

module pci_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`PCI_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire pci_pkg::pci_pins_t        port_pins,
  output logic                           change_irq,
  output logic                           change_irq_summary,
  output logic                           wake_req
);
  import pci_pkg::*;

  localparam int NP = `PCI_NUM_PORTS;

  // ****************************************
  // Port tables
  // ****************************************
  localparam logic [`PCI_IDX_W-1:0] BASE [NP] = '{
    `PCI_BASE_A, `PCI_BASE_B, `PCI_BASE_C, `PCI_BASE_E, `PCI_BASE_W
  };
  localparam pci_byte_t AVAIL [NP] = '{
    `PCI_AVAIL_A, `PCI_AVAIL_B, `PCI_AVAIL_C, `PCI_AVAIL_E,
    `PCI_AVAIL_W
  };

  // ****************************************
  // Declarations
  // ****************************************
  logic [`PCI_IDX_W-1:0] idx;
  logic                  aligned;
  logic                  setup_ph;
  logic                  access_ph;
  logic                  wr_ok;
  logic                  sel_ctrl;
  logic                  sel_stat;
  logic [NP-1:0]         sel_rise;
  logic [NP-1:0]         sel_fall;
  logic [NP-1:0]         sel_flag;
  logic                  map_hit;
  logic                  rst_pin_off;
  logic [NP-1:0]         port_any;
  logic                  any_flag;
  logic                  any_hit;
  pci_byte_t             rd_byte;
  pci_byte_t             ctrl_reg;
  pci_byte_t             rdata_reg;
  logic                  err_reg;
  logic                  irq_en;
  pci_port_regs_t        regs      [NP];
  pci_byte_t             hits      [NP];
  pci_byte_t             det_mask  [NP];
  pci_byte_t             port_rd   [NP];

  // ****************************************
  // APB decode
  // ****************************************
  // Word index and phase strobes
  assign idx       = paddr[`PCI_ADDR_W-1:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  // Writes land in the access phase, low byte lane only
  assign wr_ok     = access_ph && pwrite && pstrb[0] && aligned;
  assign sel_ctrl  = (idx == `PCI_IDX_CTRL);
  assign sel_stat  = (idx == `PCI_IDX_STAT);
  assign map_hit   = aligned
                  && (sel_ctrl || sel_stat
                  || (|sel_rise) || (|sel_fall) || (|sel_flag));

  // Control fields
  assign irq_en      = ctrl_reg[`PCI_CTRL_IE];
  assign rst_pin_off = ctrl_reg[`PCI_CTRL_EXTRST]
                    || ctrl_reg[`PCI_CTRL_LVP];

  // ****************************************
  // Per-port slices
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      // Register selects for this port
      assign sel_rise[p] = (idx == `PCI_IDX_W'(BASE[p] + `PCI_OFS_RISE));
      assign sel_fall[p] = (idx == `PCI_IDX_W'(BASE[p] + `PCI_OFS_FALL));
      assign sel_flag[p] = (idx == `PCI_IDX_W'(BASE[p] + `PCI_OFS_FLAG));

      // Reset-pin bit drops out in reset-pin or low-voltage mode
      if (p == `PCI_RSTPIN_PORT) begin : g_rst
        assign det_mask[p] = rst_pin_off
                           ? ~(8'h01 << `PCI_RSTPIN_BIT)
                           : 8'hFF;
      end else begin : g_norm
        assign det_mask[p] = 8'hFF;
      end

      // Read data of this port, zero when not selected
      assign port_rd[p] = sel_rise[p] ? regs[p].rise
                        : sel_fall[p] ? regs[p].fall
                        : sel_flag[p] ? regs[p].flags
                        : 8'h00;
      assign port_any[p] = |regs[p].flags;

      pci_port #(
        .AVAIL    (AVAIL[p])
      ) u_port (
        .pclk     (pclk),
        .presetn  (presetn),
        .pins     (port_pins[p]),
        .det_mask (det_mask[p]),
        .wr_rise  (wr_ok && sel_rise[p]),
        .wr_fall  (wr_ok && sel_fall[p]),
        .wr_flag  (wr_ok && sel_flag[p]),
        .wdata    (pwdata[7:0]),
        .regs     (regs[p]),
        .hits     (hits[p])
      );

      // Missing pins keep enables and flag clear
      chk_unavail_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((regs[p].rise | regs[p].fall | regs[p].flags)
          & ~AVAIL[p]) == 8'h00)
        else $error("bit of a missing pin is set");
      // A detected pin edge reaches the summary
      chk_port_summary: assert property (
        @(posedge pclk) disable iff (!presetn)
        (hits[p] != 8'h00) |=> change_irq_summary)
        else $error("port edge missing from summary");
    end
  endgenerate

  // ****************************************
  // Summary, request and wake
  // ****************************************
  // OR of every flag of every port
  assign any_flag = |port_any;
  assign change_irq_summary = any_flag;
  // Enable gates the request and the wake, never detection
  assign change_irq = any_flag && irq_en;

  // Any enabled edge this cycle
  always_comb begin
    any_hit = 1'b0;
    for (int i = 0; i < NP; i++) begin
      any_hit = any_hit | (|hits[i]);
    end
  end

  // Wake in the cycle the flag is written, one cycle before the flag is seen
  assign wake_req = any_hit && irq_en;

  // ****************************************
  // Read mux
  // ****************************************
  // Status write has no effect; summary reads back here
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NP; i++) begin
      rd_byte = rd_byte | port_rd[i];
    end
    if (sel_ctrl) begin
      rd_byte = ctrl_reg;
    end
    if (sel_stat) begin
      rd_byte = 8'h00;
      rd_byte[`PCI_STAT_SUM] = any_flag;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PCI_RST_BYTE;
    end else if (wr_ok && sel_ctrl) begin
      ctrl_reg <= pwdata[7:0] & `PCI_CTRL_MASK;
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  // Read data and error captured in setup, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= `PCI_RST_BYTE;
      err_reg   <= 1'b0;
    end else if (setup_ph) begin
      rdata_reg <= pwrite ? 8'h00 : rd_byte;
      err_reg   <= !map_hit;
    end
  end

  assign prdata  = {24'h000000, rdata_reg};
  assign pready  = 1'b1;                                // Zero wait
  assign pslverr = access_ph && err_reg;

  // ****************************************
  // Checks
  // ****************************************
  // All checks on the rising edge, off in reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_irq_gated: assert property (
    !irq_en |-> !change_irq)
    else $error("request raised with enable clear");
  chk_irq_follows: assert property (
    (any_hit && irq_en) |=> (change_irq || $past(wr_ok)))
    else $error("enabled edge gave no request");
  chk_detect_no_ie: assert property (
    (any_hit && !irq_en) |=> change_irq_summary)
    else $error("edge not recorded with enable clear");
  chk_summary_cause: assert property (
    $rose(change_irq_summary) |-> $past(any_hit || wr_ok))
    else $error("summary rose without edge or write");
  chk_summary_low: assert property (
    $fell(change_irq_summary) |-> $past(wr_ok)
      && (port_any == '0))
    else $error("summary fell with a flag set");
  chk_wake_flag: assert property (
    wake_req |=> change_irq_summary ##0 change_irq)
    else $error("wake before flag was recorded");
  chk_reset_pin_off: assert property (
    rst_pin_off |-> !hits[`PCI_RSTPIN_PORT][`PCI_RSTPIN_BIT])
    else $error("reset pin detected while disabled");
  chk_err_answer: assert property (
    (setup_ph && !map_hit) |=> (pslverr && pready))
    else $error("unmapped access not refused");
  chk_reset_values: assert property (
    $rose(presetn) |-> (ctrl_reg == 8'h00) && !change_irq_summary)
    else $error("reset value not zero");

  // ****************************************
  // Checks: summary and wake
  // ****************************************
  // Any stored flag keeps the summary high
  chk_summary_high: assert property (
    (port_any != '0) |-> change_irq_summary)
    else $error("flag set but summary low");
  // Status writes never move the summary
  chk_summary_ro: assert property (
    (wr_ok && sel_stat && !any_hit) |=> $stable(change_irq_summary))
    else $error("status write changed the summary");
  // Wake only with the enable, and on every enabled edge
  chk_wake_gated: assert property (
    !irq_en |-> !wake_req)
    else $error("wake raised with enable clear");
  chk_wake_on_edge: assert property (
    (any_hit && irq_en) |-> wake_req)
    else $error("enabled edge gave no wake");
  // Request falls only with the enable or the last flag
  chk_irq_holds: assert property (
    $fell(change_irq) |-> !irq_en || !change_irq_summary)
    else $error("request fell with flag and enable set");
  // Request and summary agree while the enable is set
  chk_irq_match: assert property (
    irq_en |-> (change_irq == change_irq_summary))
    else $error("request differs from summary");
  // Reset-pin bit free again once both modes are off
  chk_reset_pin_free: assert property (
    !rst_pin_off |-> (det_mask[`PCI_RSTPIN_PORT] == 8'hFF))
    else $error("reset pin masked with both modes off");

  // ****************************************
  // Checks: register bus
  // ****************************************
  // Zero-wait slave answers every access
  chk_zero_wait: assert property (
    access_ph |-> pready)
    else $error("access phase without ready");
  // Upper read lanes stay zero
  chk_upper_zero: assert property (
    prdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  // Error shown only inside an access phase
  chk_err_in_access: assert property (
    !access_ph |-> !pslverr)
    else $error("error shown outside access phase");
  // Mapped accesses always complete without error
  chk_mapped_ok: assert property (
    (setup_ph && map_hit) |=> !pslverr)
    else $error("mapped access refused");
  // Write transfers show no read data
  chk_write_no_data: assert property (
    (setup_ph && pwrite) |=> (prdata == 32'h00000000))
    else $error("write returned read data");
  // Control keeps only its defined bits
  chk_ctrl_bits: assert property (
    (ctrl_reg & ~`PCI_CTRL_MASK) == 8'h00)
    else $error("undefined control bit set");
  // Writes need the low byte lane
  chk_lane_refused: assert property (
    (access_ph && pwrite && !pstrb[0] && sel_ctrl) |=> $stable(ctrl_reg))
    else $error("write landed without its byte lane");
  // At most one register decoded at a time
  chk_one_select: assert property (
    $onehot0({sel_ctrl, sel_stat, sel_rise, sel_fall, sel_flag}))
    else $error("more than one register selected");
  // Status read returns the summary of its setup cycle
  chk_stat_read: assert property (
    (setup_ph && !pwrite && sel_stat)
      |=> (prdata[`PCI_STAT_SUM] == $past(any_flag)))
    else $error("status read lost the summary");

  // ****************************************
  // Coverage
  // ****************************************
  // Request, masked edge, locked pin, full clear
  cov_rise_irq:  cover property (any_hit && irq_en ##1 change_irq);
  cov_no_ie:     cover property (any_hit && !irq_en);
  cov_rst_block: cover property (rst_pin_off
    && port_pins[`PCI_RSTPIN_PORT][`PCI_RSTPIN_BIT]);
  cov_clear_all: cover property ($fell(change_irq_summary));
endmodule

// ===== test/pci_pin_model.sv
// Far side model: external port pins and the CPU wake input.
// Assumes the bench moves pin_req right after rising pclk edges.
`timescale 1ns/10ps

module pci_pin_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire pci_pkg::pci_pins_t pin_req,
  input  wire logic               wake_req,
  output pci_pkg::pci_pins_t      port_pins,
  output logic [7:0]              wake_count
);
  import pci_pkg::*;
  // Pins follow the request one clock later, synchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) port_pins <= '0;
    else port_pins <= pin_req;
  end
  // CPU side counts wake pulses, one per cycle seen high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wake_count <= 8'h00;
    else if (wake_req) wake_count <= wake_count + 8'h01;
  end
endmodule

// ===== test/pin_change_interrupt_test.sv
// Self-checking bench of the pin change interrupt block.
// Assumes pci_pkg and the pin model are compiled before it.
`timescale 1ns/10ps
`include "pci_regs.svh"

module pin_change_interrupt_test;
  import pci_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  pci_pins_t   pin_req, port_pins, pv;
  logic        change_irq, change_irq_summary, wake_req;
  logic [7:0]  wake_count, wk;
  int          miscompares, checks, cycles;
  logic [10:0] base [5] = '{`PCI_BASE_A, `PCI_BASE_B, `PCI_BASE_C,
                            `PCI_BASE_E, `PCI_BASE_W};

  pci_top i_pci_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pins(port_pins), .change_irq(change_irq),
    .change_irq_summary(change_irq_summary), .wake_req(wake_req));
  pci_pin_model i_pci_pin_model (.pclk(pclk), .presetn(presetn),
    .pin_req(pin_req), .wake_req(wake_req), .port_pins(port_pins),
    .wake_count(wake_count));

  // 10 MHz clock and cycle ceiling
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; pins may move with the setup phase
  task automatic apb(input logic w, input logic [10:0] idx,
                     input pci_byte_t d, input pci_pins_t p);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    pin_req <= p;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [10:0] idx, input pci_byte_t d);
    apb(1'b1, idx, d, pin_req);
  endtask
  task automatic rdc(input string what, input logic [10:0] idx,
                     input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, pin_req);
    check(what, exp, rd);
  endtask
  task automatic pins(input int port, input pci_byte_t v);
    pin_req[port] <= v;
    repeat (3) @(posedge pclk);
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    miscompares = 0;
    checks = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    pin_req = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped access, missing pins
    for (int i = 0; i < 5; i++)
      for (int r = 0; r < 3; r++)
        rdc("reset reg", base[i] + 11'(r), 32'h0);
    rdc("ctrl reset", `PCI_IDX_CTRL, 32'h0);
    apb(1'b0, 11'h000, 8'h00, pin_req);
    check("unmapped err", 32'h1, {31'h0, er});
    wr(base[2], 8'hFF);
    rdc("port c rise", base[2], 32'h7F);
    wr(base[2], 8'h00);
    // Write without the low byte lane is ignored
    pstrb <= 4'hE;
    wr(`PCI_IDX_CTRL, 8'h07);
    pstrb <= 4'hF;
    rdc("lane off ctrl", `PCI_IDX_CTRL, 32'h0);
    // Port A: rise on 0,2; fall on 1,2; bit 3 off; IE clear
    wr(base[0], 8'h05);
    wr(base[0] + 11'h1, 8'h06);
    pins(0, 8'h0F);
    rdc("rise flags", base[0] + 11'h2, 32'h05);
    check("summary ie off", 32'h1, {31'h0, change_irq_summary});
    check("irq ie off", 32'h0, {31'h0, change_irq});
    check("wake ie off", 32'h0, {24'h0, wake_count});
    wr(base[0] + 11'h2, 8'h05 & 8'hFA);
    pins(0, 8'h00);
    rdc("fall flags", base[0] + 11'h2, 32'h06);
    wr(`PCI_IDX_CTRL, 8'h01);
    repeat (2) @(posedge pclk);
    check("irq ie on", 32'h1, {31'h0, change_irq});
    // Masked clear; summary ignores writes
    wr(base[0] + 11'h2, 8'h06 & 8'hFD);
    rdc("masked clear", base[0] + 11'h2, 32'h04);
    wr(`PCI_IDX_STAT, 8'h00);
    rdc("summary ro", `PCI_IDX_STAT, 32'h1);
    wr(base[0] + 11'h2, 8'h04 & 8'hFB);
    repeat (2) @(posedge pclk);
    check("summary clear", 32'h0, {31'h0, change_irq_summary});
    check("irq clear", 32'h0, {31'h0, change_irq});
    // Wake on an enabled edge with IE set
    wk = wake_count;
    pins(0, 8'h01);
    check("wake", {24'h0, wk + 8'h01}, {24'h0, wake_count});
    rdc("wake flag", base[0] + 11'h2, 32'h01);
    pins(0, 8'h00);
    // Edge arriving during a clearing write
    pv = pin_req;
    pv[0] = 8'h01;
    apb(1'b1, base[0] + 11'h2, 8'h00, pv);
    repeat (2) @(posedge pclk);
    rdc("set wins", base[0] + 11'h2, 32'h01);
    pins(0, 8'h00);
    wr(base[0] + 11'h2, 8'h00);
    // Reset pin locked out in either mode
    wr(base[3], 8'h08);
    wr(base[3] + 11'h1, 8'h08);
    for (int m = 1; m < 3; m++) begin
      wr(`PCI_IDX_CTRL, 8'h01 | 8'(2 * m));
      pins(3, 8'h08);
      pins(3, 8'h00);
      rdc("rst pin locked", base[3] + 11'h2, 32'h00);
    end
    wr(`PCI_IDX_CTRL, 8'h01);
    pins(3, 8'h08);
    rdc("rst pin free", base[3] + 11'h2, 32'h08);
    wr(base[3] + 11'h2, 8'h00);
    // Summary from another port alone
    wr(base[4], 8'h80);
    pins(4, 8'h80);
    rdc("port w flag", base[4] + 11'h2, 32'h80);
    check("summary w", 32'h1, {31'h0, change_irq_summary});
    final_report;
  end
endmodule
